// >>> asr_pkg.sv
// Purpose: constants and types for the ALU flag and CPU status registers
// Assumes: one clock, registers reached over a plain address/strobe port
// Notes: Summary of operation
// Summary of operation
// - Flag-updating op on flag register overrides write
// - Clear of flag register: modes zero, zero set
// - Subtraction carries are inverted borrows
// - Overflow set on signed result out of range
// - Bits 7-6 select pointer one post-update
// - Bits 5-4 select pointer zero post-update
// - Power-on reset sets mode bits to one
// - Zero flag follows result equal zero
// - Nibble carry from bit three on add
// - Carry out of bit seven on add
// - Rotate through carry loads shifted-out bit
// - Operands: working register, file register, immediate
// - Timeout, power-down, stack-available ignore writes
// - Stack available clears at Fh, locks on wrap
// - Global disable blocks all interrupts
// - Timeout set by power-up, watchdog clear; cleared timeout
// - Power-down set by power-up, watchdog clear; cleared sleep
// - Power-on bit cleared by power-on, software sets
// - Brown-out bit cleared by brown-out, software sets
// - Status bits 7-6 read zero
package asr_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ASR_ALU_FLAG_OFS = 8'h04; // Flag register address
	localparam logic [7:0] ASR_CPU_STAT_OFS = 8'h06; // Status register address
	// ****************************************
	// Bit positions
	// ****************************************
	localparam int ASR_C_BIT = 0; // Carry
	localparam int ASR_DC_BIT = 1; // Nibble carry
	localparam int ASR_Z_BIT = 2; // Zero
	localparam int ASR_OV_BIT = 3; // Signed overflow
	localparam int ASR_P0_LO = 4; // Pointer zero mode low bit
	localparam int ASR_P1_LO = 6; // Pointer one mode low bit
	localparam int ASR_BOR_BIT = 0; // Brown-out status
	localparam int ASR_POR_BIT = 1; // Power-on status
	localparam int ASR_PD_BIT = 2; // Power-down status
	localparam int ASR_TO_BIT = 3; // Timeout status
	localparam int ASR_GID_BIT = 4; // Global interrupt disable
	localparam int ASR_SKA_BIT = 5; // Stack available
	localparam logic [7:0] ASR_FLAG_MASK = 8'h0f; // Result flag bits
	localparam logic [7:0] ASR_STAT_WMASK = 8'h13; // Writable status bits
	localparam logic [7:0] ASR_STAT_IMPL = 8'h3f; // Implemented status bits
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [3:0] ASR_MODE_RST = 4'hf; // Pointer modes after power-on
	localparam logic [3:0] ASR_FLAG_RST = 4'h0; // Flags unknown; modelled as zero
	localparam logic [7:0] ASR_STAT_POR = 8'h3d; // Status after power-on
	localparam logic [3:0] ASR_SP_TOP = 4'hf; // Stack pointer top
	localparam logic [1:0] ASR_MODE_DEC = 2'h0; // Post-decrement
	localparam logic [1:0] ASR_MODE_INC = 2'h1; // Post-increment
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		ASR_OP_NONE = 4'h0, // No ALU result
		ASR_OP_ADD = 4'h1, // Add
		ASR_OP_SUB = 4'h2, // Subtract (src minus working)
		ASR_OP_AND = 4'h3, // Logic and
		ASR_OP_IOR = 4'h4, // Logic or
		ASR_OP_XOR = 4'h5, // Logic exclusive or
		ASR_OP_RLC = 4'h6, // Rotate left through carry
		ASR_OP_RRC = 4'h7, // Rotate right through carry
		ASR_OP_CLR = 4'h8, // Clear register
		ASR_OP_MOV = 4'h9 // Direct write, no flags
	} asr_op_e;
	typedef struct packed {
		asr_op_e op; // Operation
		logic use_imm; // Second operand is immediate
		logic [7:0] imm; // Immediate value
		logic [7:0] faddr; // Destination file address
		logic dest_file; // Result goes to file register
	} asr_cmd_s;
	typedef struct packed {
		logic por; // Power-on reset event
		logic bor; // Brown-out reset event
		logic wdt_clear; // Watchdog clear instruction
		logic wdt_timeout; // Watchdog time-out
		logic sleep; // Sleep instruction
		logic push; // Stack push
		logic pop; // Stack pop
	} asr_evt_s;
endpackage

// >>> asr_status_regs.sv
// Purpose: ALU result flags, pointer modes and CPU status register
// Assumes: core drives one command per cycle; events from same clock
// Notes: arst_n is the power-on reset; device events arrive as pulses
//
// The strobed register port was chosen for this implementation.
module asr_status_regs import asr_pkg::*; (
	input wire logic ref_clk, // Clock
	input wire logic arst_n, // Power-on reset, active low
	input wire logic [7:0] addr, // Register address
	input wire logic [7:0] wdata, // Write data
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	output logic [7:0] rdata, // Read data, cycle after strobe
	input wire logic cmd_valid, // ALU command strobe
	input wire asr_cmd_s cmd, // ALU command
	input wire logic [7:0] file_val, // File register operand
	input wire logic [7:0] working_register, // Working register operand
	output logic [7:0] result, // ALU result, registered
	input wire asr_evt_s evt, // Device events
	input wire logic brown_out_enable_config, // Brown-out enable
	input wire logic [7:0] irq_req, // Enabled interrupt requests
	output logic irq_take, // Interrupt accepted
	output logic [1:0] pointer0_mode, // Pointer zero post-update mode
	output logic [1:0] pointer1_mode, // Pointer one post-update mode
	output logic [1:0] ptr0_step, // Pointer zero: 01 inc, 11 dec, 00 hold
	output logic [1:0] ptr1_step // Pointer one: 01 inc, 11 dec, 00 hold
);
	// ****************************************
	// State
	// ****************************************
	logic [7:0] alu_flag_reg; // Flag register
	logic [7:0] cpu_status_reg; // Status register
	logic [3:0] sp_reg; // Stack pointer
	logic ska_lock_reg; // Stack available locked clear
	logic [7:0] opb; // Second operand
	logic [8:0] sum; // Wide result
	logic [4:0] nib; // Low nibble sum
	logic [7:0] res; // Result byte
	logic c_new, dc_new, ov_new, fl_upd; // New flags
	logic hit_flag, hit_stat; // Destination decode
	logic [3:0] sp_next; // Next stack pointer

	// ****************************************
	// ALU
	// ****************************************
	// Operand select
	assign opb = cmd.use_imm ? cmd.imm : file_val;
	// Combinational result and flags
	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		res = 8'h00;
		c_new = alu_flag_reg[ASR_C_BIT];
		dc_new = alu_flag_reg[ASR_DC_BIT];
		ov_new = alu_flag_reg[ASR_OV_BIT];
		fl_upd = 1'b1;
		case (cmd.op)
			ASR_OP_ADD: begin
				sum = {1'b0, opb} + {1'b0, working_register};
				nib = {1'b0, opb[3:0]} + {1'b0, working_register[3:0]};
				res = sum[7:0];
				c_new = sum[8];
				dc_new = nib[4];
				ov_new = (opb[7] == working_register[7]) && (res[7] != opb[7]);
			end
			ASR_OP_SUB: begin
				// Add two's complement; carry one means no borrow
				sum = {1'b0, opb} + {1'b0, ~working_register} + 9'h001;
				nib = {1'b0, opb[3:0]} + {1'b0, ~working_register[3:0]} + 5'h01;
				res = sum[7:0];
				c_new = sum[8];
				dc_new = nib[4];
				ov_new = (opb[7] != working_register[7]) && (res[7] != opb[7]);
			end
			ASR_OP_AND: res = opb & working_register;
			ASR_OP_IOR: res = opb | working_register;
			ASR_OP_XOR: res = opb ^ working_register;
			ASR_OP_RLC: begin
				res = {opb[6:0], alu_flag_reg[ASR_C_BIT]};
				c_new = opb[7];
			end
			ASR_OP_RRC: begin
				res = {alu_flag_reg[ASR_C_BIT], opb[7:1]};
				c_new = opb[0];
			end
			ASR_OP_CLR: res = 8'h00;
			ASR_OP_MOV: begin
				res = opb;
				fl_upd = 1'b0;
			end
			default: fl_upd = 1'b0;
		endcase
	end

	// An empty command never lands in either register
	assign hit_flag = cmd_valid && cmd.dest_file && (cmd.op != ASR_OP_NONE) &&
		(cmd.faddr == ASR_ALU_FLAG_OFS);
	assign hit_stat = cmd_valid && cmd.dest_file && (cmd.op != ASR_OP_NONE) &&
		(cmd.faddr == ASR_CPU_STAT_OFS);

	// Registered result
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			result <= 8'h00;
		end else if (cmd_valid) begin
			result <= res;
		end
	end

	// ****************************************
	// Flag register
	// ****************************************
	// Power-on sets modes; flags updated by ALU or plain writes
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			alu_flag_reg <= {ASR_MODE_RST, ASR_FLAG_RST};
		end else if (evt.por) begin
			// Power-on event acts like the pin reset
			alu_flag_reg <= {ASR_MODE_RST, ASR_FLAG_RST};
		end else if (cmd_valid && fl_upd) begin
			if (hit_flag) begin
				// Flag bits follow the result, mode bits take result bits 7-4
				alu_flag_reg[7:4] <= res[7:4];
			end
			alu_flag_reg[ASR_Z_BIT] <= (res == 8'h00);
			if (cmd.op inside {ASR_OP_ADD, ASR_OP_SUB}) begin
				alu_flag_reg[ASR_DC_BIT] <= dc_new;
				alu_flag_reg[ASR_OV_BIT] <= ov_new;
			end
			if (cmd.op inside {ASR_OP_ADD, ASR_OP_SUB, ASR_OP_RLC, ASR_OP_RRC}) begin
				alu_flag_reg[ASR_C_BIT] <= c_new;
			end
		end else if (hit_flag) begin
			alu_flag_reg <= res;
		end else if (wr_en && addr == ASR_ALU_FLAG_OFS) begin
			alu_flag_reg <= wdata;
		end
	end

	// Pointer mode outputs
	assign pointer1_mode = alu_flag_reg[ASR_P1_LO +: 2];
	assign pointer0_mode = alu_flag_reg[ASR_P0_LO +: 2];
	// Step encoding: 1x holds
	always_comb begin
		ptr0_step = pointer0_mode[1] ? 2'h0 : (pointer0_mode == ASR_MODE_INC ? 2'h1 : 2'h3);
		ptr1_step = pointer1_mode[1] ? 2'h0 : (pointer1_mode == ASR_MODE_INC ? 2'h1 : 2'h3);
	end

	// ****************************************
	// Stack tracking
	// ****************************************
	always_comb begin
		sp_next = sp_reg;
		if (evt.push && !evt.pop) begin
			sp_next = sp_reg + 4'h1;
		end else if (evt.pop && !evt.push) begin
			sp_next = sp_reg - 4'h1;
		end
	end

	// Pointer and overflow lock
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sp_reg <= 4'h0;
			ska_lock_reg <= 1'b0;
		end else if (evt.por || evt.bor) begin
			sp_reg <= 4'h0;
			ska_lock_reg <= 1'b0;
		end else begin
			sp_reg <= sp_next;
			if (evt.push && !evt.pop && sp_reg == ASR_SP_TOP) begin
				ska_lock_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// Status register
	// ****************************************
	// Event bits set by device, software writes only writable bits
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_status_reg <= ASR_STAT_POR;
		end else begin
			if (hit_stat) begin
				cpu_status_reg[ASR_GID_BIT] <= res[ASR_GID_BIT];
				cpu_status_reg[ASR_POR_BIT] <= res[ASR_POR_BIT];
				cpu_status_reg[ASR_BOR_BIT] <= res[ASR_BOR_BIT];
			end else if (wr_en && addr == ASR_CPU_STAT_OFS) begin
				cpu_status_reg[ASR_GID_BIT] <= wdata[ASR_GID_BIT];
				cpu_status_reg[ASR_POR_BIT] <= wdata[ASR_POR_BIT];
				cpu_status_reg[ASR_BOR_BIT] <= wdata[ASR_BOR_BIT];
			end
			// Power-on event clears power-on bit, brown-out event clears brown-out bit; wins over software
			if (evt.por) begin
				cpu_status_reg <= ASR_STAT_POR;
			end else if (evt.bor && brown_out_enable_config) begin
				cpu_status_reg[ASR_BOR_BIT] <= 1'b0;
				cpu_status_reg[ASR_GID_BIT] <= 1'b1;
			end
			// Watchdog and sleep; time-out and sleep win over clear
			if (evt.wdt_timeout) begin
				cpu_status_reg[ASR_TO_BIT] <= 1'b0;
			end else if (evt.wdt_clear) begin
				cpu_status_reg[ASR_TO_BIT] <= 1'b1;
			end
			if (evt.sleep) begin
				cpu_status_reg[ASR_PD_BIT] <= 1'b0;
			end else if (evt.wdt_clear) begin
				cpu_status_reg[ASR_PD_BIT] <= 1'b1;
			end
			// Stack available from pointer
			if (!evt.por && !evt.bor) begin
				cpu_status_reg[ASR_SKA_BIT] <= !(ska_lock_reg || sp_next == ASR_SP_TOP ||
					(evt.push && !evt.pop && sp_reg == ASR_SP_TOP));
			end
		end
	end

	// Global interrupt gate
	assign irq_take = !cpu_status_reg[ASR_GID_BIT] && (|irq_req);

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else if (rd_en && addr == ASR_ALU_FLAG_OFS) begin
			rdata <= alu_flag_reg;
		end else if (rd_en && addr == ASR_CPU_STAT_OFS) begin
			rdata <= cpu_status_reg & ASR_STAT_IMPL;
		end else begin
			rdata <= 8'h00;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence clr_flag_s;
		cmd_valid && cmd.op == ASR_OP_CLR && hit_flag && !evt.por;
	endsequence
	clr_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		clr_flag_s |=> alu_flag_reg[7:4] == 4'h0 && alu_flag_reg[ASR_Z_BIT]
		&& alu_flag_reg[1:0] == $past(alu_flag_reg[1:0]) && alu_flag_reg[3] == $past(alu_flag_reg[3]))
		else $error("clear of flag register wrong");
	add_carry_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		cmd_valid && cmd.op == ASR_OP_ADD && !hit_flag && !evt.por |=>
		alu_flag_reg[ASR_C_BIT] == $past(sum[8]))
		else $error("add carry wrong");
	zero_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		cmd_valid && fl_upd && !evt.por |=> alu_flag_reg[ASR_Z_BIT] == (result == 8'h00))
		else $error("zero flag wrong");
	sub_borrow_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		cmd_valid && cmd.op == ASR_OP_SUB && !evt.por |=>
		alu_flag_reg[ASR_C_BIT] == ($past(opb) >= $past(working_register)))
		else $error("borrow polarity wrong");
	stat_ro_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wr_en && addr == ASR_CPU_STAT_OFS && !cmd_valid && !evt.wdt_clear && !evt.wdt_timeout
		&& !evt.sleep && !evt.por && !evt.bor |=> cpu_status_reg[3:2] == $past(cpu_status_reg[3:2]))
		else $error("read-only status bit written");
	sleep_pd_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		evt.sleep && !evt.por |=> !cpu_status_reg[ASR_PD_BIT])
		else $error("power-down not cleared by sleep");
	wdt_to_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		evt.wdt_clear && !evt.wdt_timeout |=> cpu_status_reg[ASR_TO_BIT])
		else $error("timeout not set by watchdog clear");
	stack_lock_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		ska_lock_reg && !evt.por && !evt.bor |=> !cpu_status_reg[ASR_SKA_BIT])
		else $error("stack available set while locked");
	gid_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		cpu_status_reg[ASR_GID_BIT] |-> !irq_take)
		else $error("interrupt taken while disabled");
	read_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		rd_en && addr == ASR_CPU_STAT_OFS |=> rdata[7:6] == 2'h0)
		else $error("unimplemented status bits read nonzero");
	por_mode_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		evt.por |=> alu_flag_reg[7:4] == ASR_MODE_RST)
		else $error("pointer modes not set by power-on event");
endmodule

// >>> tb.sv
// Purpose: self-checking bench for the ALU flag and CPU status registers
// Assumes: register port with one-cycle strobes, read data the cycle after
// Notes: every stimulus is driven just after a rising edge
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); error_cnt++; end end
module tb import asr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic ref_clk = 1'b0; // Clock
	logic arst_n = 1'b0; // Power-on reset
	logic [7:0] addr = 8'h00, wdata = 8'h00, file_val = 8'h00, working_register = 8'h00;
	logic wr_en = 1'b0, rd_en = 1'b0, cmd_valid = 1'b0; // Strobes
	asr_cmd_s cmd = '0; // ALU command
	asr_evt_s evt = '0; // Device events
	logic brown_out_enable_config = 1'b1; // Brown-out circuit on
	logic [7:0] irq_req = 8'h00; // Enabled requests
	logic [7:0] rdata, result; // Read data, ALU result
	logic irq_take; // Interrupt accepted
	logic [1:0] p0m, p1m, p0s, p1s; // Pointer modes and steps
	int error_cnt = 0; // Mismatches
	int samples_checked = 0; // Comparisons
	logic [1:0] es; // Expected pointer step
	always #10 ref_clk = ~ref_clk; // 50 MHz
	asr_status_regs asr_status_regs_inst (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cmd_valid(cmd_valid),
		.cmd(cmd), .file_val(file_val), .working_register(working_register), .result(result),
		.evt(evt), .brown_out_enable_config(brown_out_enable_config), .irq_req(irq_req),
		.irq_take(irq_take), .pointer0_mode(p0m), .pointer1_mode(p1m), .ptr0_step(p0s),
		.ptr1_step(p1s));
	// ****************************************
	// Bus and command tasks
	// ****************************************
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	// One-cycle read strobe; data checked in the following cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		`CHK("rdata", ex, rdata)
	endtask
	// One ALU command, optionally clashing with a flag register write
	task automatic alu(input asr_op_e op, input logic [7:0] fv, input logic [7:0] wv,
		input logic ui, input logic [7:0] im, input logic df, input logic [7:0] er,
		input logic [7:0] ef);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, use_imm: ui, imm: im, faddr: (df ? ASR_ALU_FLAG_OFS : 8'h20),
			dest_file: df};
		file_val <= fv;
		working_register <= wv;
		wr_en <= df;
		addr <= ASR_ALU_FLAG_OFS;
		wdata <= 8'h00;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		wr_en <= 1'b0;
		#1;
		`CHK("result", er, result)
		rd(ASR_ALU_FLAG_OFS, ef);
	endtask
	// Single-cycle device event pulse
	task automatic ev(input asr_evt_s e);
		@(posedge ref_clk);
		evt <= e;
		@(posedge ref_clk);
		evt <= '0;
	endtask
	// Verdict and end of run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ****************************************
	// Watchdog: tests take well under 1000 cycles
	// ****************************************
	initial begin
		#(20 * 5000);
		error_cnt++;
		give_verdict();
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(ASR_ALU_FLAG_OFS, 8'hf0);
		rd(ASR_CPU_STAT_OFS, 8'h3d);
		rd(8'h05, 8'h00);
		$display("test reset done");
		// Writable and fixed status bits
		wr(ASR_CPU_STAT_OFS, 8'hff);
		rd(ASR_CPU_STAT_OFS, 8'h3f);
		wr(ASR_CPU_STAT_OFS, 8'h00);
		irq_req <= 8'h01;
		rd(ASR_CPU_STAT_OFS, 8'h2c);
		`CHK("irq_take", 1'b1, irq_take)
		wr(ASR_CPU_STAT_OFS, 8'h13);
		rd(ASR_CPU_STAT_OFS, 8'h3f);
		`CHK("irq_take", 1'b0, irq_take)
		$display("test status write done");
		// Watchdog, sleep and brown-out events
		wr(ASR_CPU_STAT_OFS, 8'h03);
		ev('{wdt_timeout: 1'b1, default: 1'b0});
		rd(ASR_CPU_STAT_OFS, 8'h27);
		ev('{bor: 1'b1, default: 1'b0});
		rd(ASR_CPU_STAT_OFS, 8'h36);
		ev('{wdt_clear: 1'b1, default: 1'b0});
		rd(ASR_CPU_STAT_OFS, 8'h3e);
		ev('{sleep: 1'b1, default: 1'b0});
		rd(ASR_CPU_STAT_OFS, 8'h3a);
		ev('{wdt_clear: 1'b1, default: 1'b0});
		$display("test events done");
		// Stack fill, wrap lock, then power-on event releases it
		repeat (14) ev('{push: 1'b1, default: 1'b0});
		rd(ASR_CPU_STAT_OFS, 8'h3e);
		ev('{push: 1'b1, default: 1'b0});
		rd(ASR_CPU_STAT_OFS, 8'h1e);
		ev('{push: 1'b1, default: 1'b0});
		repeat (2) ev('{pop: 1'b1, default: 1'b0});
		rd(ASR_CPU_STAT_OFS, 8'h1e);
		ev('{por: 1'b1, default: 1'b0});
		rd(ASR_CPU_STAT_OFS, 8'h3d);
		$display("test stack done");
		// Pointer modes: every code on both pointers
		for (int m = 0; m < 4; m++) begin
			wr(ASR_ALU_FLAG_OFS, {m[1:0], m[1:0], 4'h0});
			rd(ASR_ALU_FLAG_OFS, {m[1:0], m[1:0], 4'h0});
			es = (m == 0) ? 2'b11 : ((m == 1) ? 2'b01 : 2'b00);
			`CHK("pointer0_mode", m[1:0], p0m)
			`CHK("pointer1_mode", m[1:0], p1m)
			`CHK("ptr0_step", es, p0s)
			`CHK("ptr1_step", es, p1s)
		end
		$display("test pointer modes done");
		// Arithmetic and logic flags
		alu(ASR_OP_ADD, 8'h7f, 8'h01, 1'b0, 8'h00, 1'b0, 8'h80, 8'hfa);
		alu(ASR_OP_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 1'b0, 8'h00, 8'hf7);
		alu(ASR_OP_SUB, 8'h05, 8'h03, 1'b0, 8'h00, 1'b0, 8'h02, 8'hf3);
		alu(ASR_OP_SUB, 8'h03, 8'h05, 1'b0, 8'h00, 1'b0, 8'hfe, 8'hf0);
		alu(ASR_OP_SUB, 8'h80, 8'h01, 1'b0, 8'h00, 1'b0, 8'h7f, 8'hf9);
		alu(ASR_OP_RLC, 8'h81, 8'h00, 1'b0, 8'h00, 1'b0, 8'h03, 8'hf9);
		alu(ASR_OP_RRC, 8'h02, 8'h00, 1'b0, 8'h00, 1'b0, 8'h81, 8'hf8);
		alu(ASR_OP_AND, 8'h0f, 8'hf0, 1'b0, 8'h00, 1'b0, 8'h00, 8'hfc);
		alu(ASR_OP_XOR, 8'h00, 8'h3c, 1'b1, 8'h3c, 1'b0, 8'h00, 8'hfc);
		alu(ASR_OP_IOR, 8'h10, 8'h01, 1'b0, 8'h00, 1'b0, 8'h11, 8'hf8);
		$display("test alu flags done");
		// Flag register as destination
		alu(ASR_OP_CLR, 8'hf8, 8'h00, 1'b0, 8'h00, 1'b1, 8'h00, 8'h0c);
		alu(ASR_OP_ADD, 8'h50, 8'h50, 1'b0, 8'h00, 1'b1, 8'ha0, 8'ha8);
		ev('{por: 1'b1, default: 1'b0});
		rd(ASR_ALU_FLAG_OFS, 8'hf0);
		$display("test flag destination done");
		give_verdict();
	end
endmodule
